// >>> rtl/wdt_pkg.sv
package wdt_pkg;
  // ----------------------------------------
  // clock and oscillator rates
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned LF_HZ  = 31_000;
  localparam int unsigned MF_HZ  = 31_250;
  // cycles per oscillator tick, rounded down
  localparam int unsigned LF_DIV = CLK_HZ / LF_HZ;
  localparam int unsigned MF_DIV = CLK_HZ / MF_HZ;
  localparam int unsigned DIV_W  = 14;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] A_CAUSE = 3'h0;
  localparam logic [2:0] A_CTRL0 = 3'h1;
  localparam logic [2:0] A_CTRL1 = 3'h2;
  localparam logic [2:0] A_TMR   = 3'h3;

  // reset_cause_reg bit positions
  localparam int unsigned B_OVF  = 7;
  localparam int unsigned B_UNF  = 6;
  localparam int unsigned B_WV   = 5;
  localparam int unsigned B_WDT  = 4;
  localparam int unsigned B_EXT  = 3;
  localparam int unsigned B_INSTR = 2;
  localparam int unsigned B_PWR  = 1;
  localparam int unsigned B_BRN  = 0;
  // value after power-on or brown-out
  localparam logic [7:0] CAUSE_PWR = 8'h3C;

  // ----------------------------------------
  // configuration codes
  // ----------------------------------------
  localparam logic [1:0] EN_OFF   = 2'h0;
  localparam logic [1:0] EN_SW    = 2'h1;
  localparam logic [1:0] EN_AWAKE = 2'h2;
  localparam logic [1:0] EN_ON    = 2'h3;
  localparam logic [4:0] PS_SW    = 5'h1F;
  localparam logic [4:0] PS_DEF   = 5'h0B;
  localparam logic [4:0] PS_MAX   = 5'h12;
  localparam logic [4:0] PS_BASE  = 5'h05;
  localparam logic [2:0] CS_SW    = 3'h7;
  localparam logic [2:0] CS_MF    = 3'h1;
  localparam logic [2:0] WIN_SW   = 3'h7;
  localparam int unsigned CNT_W   = 23;
endpackage

// >>> rtl/windowed_watchdog.sv
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// R1: stack overflow sets bit 7; power-on or brown-out loads 0.
// R2: stack underflow sets bit 6; power events clear it; firmware may clear.
// R3: window violation clears bit 5; power events and firmware set it.
// R4: watchdog time-out reset clears bit 4; power events set it.
// R5: external pin reset clears bit 3; power events set it.
// R6: reset instruction clears bit 2; power events set it.
// R7: power-on flag bit 1 loads 0 on power events, else changed only by firmware writes.
// R8: brown-out flag bit 0 loads 0 on power events, else changed only by firmware writes.
// R9: firmware writes to flags are kept until the next hardware event.
// R10: time-out without a clear resets the device.
// R11: time base is low or mid oscillator, chosen by configuration.
// R12: in software mode the enable bit and clock field control it.
// R13: mode 11 always active; mode 00 always disabled.
// R14: mode 10 active awake, disabled in sleep.
// R15: period field used only when configured period is all ones.
// R16: default period after reset is two seconds nominal.
// R17: clear outside the window resets and clears the violation flag.
// R18: window field used only when configured window is 111.
// R19: window open decided from the counter value.
// R20: counter cleared on resets, clears, sleep edges, disable, startup, writes.
// R21: in windowed mode an unarmed clear is a violation.
// R22: time-out in sleep wakes the device instead of resetting.
// R23: period code 0 is 1:32, doubling per code; above 10010 minimum.
// R24: clear and write events reach the counter on the oscillator tick.
module windowed_watchdog
  import wdt_pkg::*;
#(
  parameter int unsigned LF_CYC = wdt_pkg::LF_DIV,
  parameter int unsigned MF_CYC = wdt_pkg::MF_DIV
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [wdt_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                wr_data,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  output logic      [7:0]                rd_data_q,
  input  wire logic [1:0]                watchdog_enable_cfg,
  input  wire logic [2:0]                cfg_clock_select,
  input  wire logic [4:0]                cfg_period_select,
  input  wire logic [2:0]                cfg_window_select,
  input  wire logic                      sleep,
  input  wire logic                      int_wake,
  input  wire logic                      osc_startup_running,
  input  wire logic                      clear_watchdog_instr,
  input  wire logic                      brownout_event,
  input  wire logic                      ext_reset_pin_event,
  input  wire logic                      reset_instr_event,
  input  wire logic                      stack_overflow_event,
  input  wire logic                      stack_underflow_event,
  output logic                           wdt_reset_q,
  output logic                           wake_q
);
  import wdt_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [4:0]       ps_q;
  logic             sw_enable_q;
  logic [2:0]       cs_q;
  logic [2:0]       win_q;
  logic [7:0]       cause_q;
  logic [7:0]       cause_d;
  logic [CNT_W-1:0] cnt_q;
  logic [DIV_W-1:0] div_q;
  logic             armed_q;
  logic             pend_q;
  logic             sleep_q;

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  wire       pwr_rst = !rst_n || brownout_event;
  wire       any_rst = pwr_rst || ext_reset_pin_event
                       || reset_instr_event || wdt_reset_q;
  wire       ps_sw   = cfg_period_select == PS_SW;
  // period field only when configured all ones [R15]
  wire [4:0] ps_raw  = ps_sw ? ps_q : cfg_period_select;
  // reserved codes fall back to the shortest period [R23]
  wire [4:0] ps_eff  = (ps_raw > PS_MAX) ? 5'h00 : ps_raw;
  // window field only when configured 111 [R18]
  wire [2:0] win_eff = (cfg_window_select == WIN_SW) ? win_q
                                                     : cfg_window_select;
  wire       windowed = win_eff != WIN_SW;
  // software mode takes the clock field, else configuration [R11] [R12]
  wire [2:0] cs_eff  = (watchdog_enable_cfg == EN_SW) ? cs_q
                                                      : cfg_clock_select;
  wire       use_mf  = cs_eff == CS_MF;

  // operating mode [R13] [R14] [R12]
  logic active;
  always_comb begin
    case (watchdog_enable_cfg)
      EN_ON:    active = 1'b1;
      EN_AWAKE: active = !sleep;
      EN_SW:    active = sw_enable_q;
      default:  active = 1'b0;
    endcase
  end

  // ----------------------------------------
  // oscillator tick divider
  // ----------------------------------------
  // a time base derived from clk stands in for the internal oscillators
  wire [DIV_W-1:0] div_lim = use_mf ? DIV_W'(MF_CYC - 1)
                                    : DIV_W'(LF_CYC - 1);
  wire tick = div_q >= div_lim; // >= survives a source switch [R11]

  always_ff @(posedge clk) begin
    if (!rst_n || tick)
      div_q <= '0;
    else
      div_q <= div_q + DIV_W'(1);
  end

  // ----------------------------------------
  // counter, window and events
  // ----------------------------------------
  // period of 32 << code ticks, 65536 ticks for the default code [R23]
  wire [CNT_W:0]   span = (CNT_W+1)'(1) << (PS_BASE + ps_eff);
  wire [CNT_W-1:0] last = CNT_W'(span - (CNT_W+1)'(1));
  // counter scaled to five bits, top three give the eighth
  wire [CNT_W-1:0] tmr_w  = cnt_q >> ps_eff;
  wire [4:0]       tmr5   = tmr_w[4:0];
  wire win_open = tmr5[4:2] >= (3'h7 - win_eff); // [R19]

  wire clr_hit   = clear_watchdog_instr && active;
  // in windowed mode, unarmed or closed-window clears are violations [R17] [R21]
  wire clr_ok    = clr_hit && (!windowed || (armed_q && win_open));
  wire violation = clr_hit && !clr_ok;
  wire ctrl_wr   = wr_en && (addr == A_CTRL0 || addr == A_CTRL1);
  wire sleep_edge = sleep != sleep_q;
  wire hard_clr  = any_rst || !active || osc_startup_running
                   || sleep_edge || int_wake;
  wire new_pend  = clr_ok || ctrl_wr;
  // a clear issued on the last tick still saves the device
  wire timeout   = tick && cnt_q == last && !pend_q
                   && !new_pend && !hard_clr;

  // counter clears; processor events wait for the tick [R20] [R24]
  always_ff @(posedge clk) begin
    if (hard_clr)
      cnt_q <= '0;
    else if (tick)
      cnt_q <= (pend_q || timeout) ? '0 : cnt_q + CNT_W'(1);
  end

  // pending clear, consumed on the next tick [R24]
  always_ff @(posedge clk) begin
    if (hard_clr)
      pend_q <= 1'b0;
    else if (new_pend)
      pend_q <= 1'b1;
    else if (tick)
      pend_q <= 1'b0;
  end

  // read of control 0 arms, any clear while active disarms [R21]
  always_ff @(posedge clk) begin
    if (any_rst)
      armed_q <= 1'b0;
    else if (clr_hit)
      armed_q <= 1'b0;
    else if (rd_en && addr == A_CTRL0)
      armed_q <= 1'b1;
  end

  // reset or wake request, one cycle each [R10] [R17] [R22]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdt_reset_q <= 1'b0;
      wake_q      <= 1'b0;
      sleep_q     <= 1'b0;
    end else begin
      wdt_reset_q <= violation || (timeout && !sleep);
      wake_q      <= timeout && sleep;
      sleep_q     <= sleep;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // reload from configuration on every reset; 2 s default [R16]
  always_ff @(posedge clk) begin
    if (any_rst) begin
      ps_q  <= ps_sw ? PS_DEF : cfg_period_select;
      sw_enable_q <= 1'b0;
      cs_q  <= (cfg_clock_select == CS_SW) ? 3'h0 : cfg_clock_select;
      win_q <= cfg_window_select;
    end else if (wr_en && addr == A_CTRL0) begin
      if (ps_sw)
        ps_q <= wr_data[5:1];
      sw_enable_q <= wr_data[0]; // [R12]
    end else if (wr_en && addr == A_CTRL1) begin
      if (cfg_clock_select == CS_SW)
        cs_q <= wr_data[6:4];
      if (cfg_window_select == WIN_SW)
        win_q <= wr_data[2:0];
    end
  end

  // ----------------------------------------
  // reset cause flags
  // ----------------------------------------
  // firmware write and any hardware cause event in this cycle
  wire cause_wr = wr_en && addr == A_CAUSE;
  wire cause_hw = stack_overflow_event || stack_underflow_event || violation
                  || (timeout && !sleep) || ext_reset_pin_event || reset_instr_event;

  // firmware value first, hardware events override it [R9]
  always_comb begin
    cause_d = cause_wr ? wr_data : cause_q;
    if (stack_overflow_event)
      cause_d[B_OVF] = 1'b1; // [R1]
    if (stack_underflow_event)
      cause_d[B_UNF] = 1'b1; // [R2]
    if (violation)
      cause_d[B_WV] = 1'b0; // [R3]
    if (timeout && !sleep)
      cause_d[B_WDT] = 1'b0; // [R4]
    if (ext_reset_pin_event)
      cause_d[B_EXT] = 1'b0; // [R5]
    if (reset_instr_event)
      cause_d[B_INSTR] = 1'b0; // [R6]
  end

  // power events load the fixed pattern [R1] [R2] [R3] [R7] [R8]
  always_ff @(posedge clk) begin
    if (pwr_rst)
      cause_q <= CAUSE_PWR;
    else
      cause_q <= cause_d;
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  wire [7:0] rd_mux =
    (addr == A_CAUSE) ? cause_q :
    (addr == A_CTRL0) ? {2'h0, ps_q, sw_enable_q} :
    (addr == A_CTRL1) ? {1'b0, cs_q, 1'b0, win_q} :
    (addr == A_TMR)   ? {tmr5, active, 2'h0} : 8'h00;

  // data only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n || !rd_en)
      rd_data_q <= 8'h00;
    else
      rd_data_q <= rd_mux;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  timeout_reset_a: assert property ( // [R10]
    @(posedge clk) disable iff (!rst_n)
    timeout && !sleep |=> wdt_reset_q && !wake_q)
    else $error("time-out did not reset");

  sleep_wake_a: assert property ( // [R22]
    @(posedge clk) disable iff (!rst_n)
    timeout && sleep |=> wake_q && !wdt_reset_q)
    else $error("sleep time-out did not wake");

  violation_flag_a: assert property ( // [R17]
    @(posedge clk) disable iff (!rst_n)
    violation && !brownout_event |=> !cause_q[B_WV] && wdt_reset_q)
    else $error("violation not recorded");

  unarmed_clear_a: assert property ( // [R21]
    @(posedge clk) disable iff (!rst_n)
    clr_hit && windowed && !armed_q |=> wdt_reset_q)
    else $error("unarmed clear accepted");

  mode_off_a: assert property ( // [R13]
    @(posedge clk) disable iff (!rst_n)
    watchdog_enable_cfg == EN_OFF |=> cnt_q == '0 && !pend_q)
    else $error("counter ran while disabled");

  sleep_off_a: assert property ( // [R14]
    @(posedge clk) disable iff (!rst_n)
    watchdog_enable_cfg == EN_AWAKE && sleep |=> cnt_q == '0)
    else $error("counter ran in sleep");

  power_flags_a: assert property ( // [R7]
    @(posedge clk)
    !rst_n |=> cause_q == CAUSE_PWR)
    else $error("power-on flags wrong");

  overflow_set_a: assert property ( // [R1]
    @(posedge clk) disable iff (!rst_n)
    stack_overflow_event && !brownout_event |=> cause_q[B_OVF])
    else $error("overflow flag not set");

  ctrl_write_a: assert property ( // [R20]
    @(posedge clk) disable iff (!rst_n)
    ctrl_wr |=> pend_q || cnt_q == '0)
    else $error("write did not clear counter");

  period_wrap_a: assert property ( // [R23]
    @(posedge clk) disable iff (!rst_n)
    timeout |=> cnt_q == '0)
    else $error("counter did not wrap");

  // flag checks leave out brown-out, which loads the fixed pattern
  underflow_set_a: assert property ( // [R2]
    @(posedge clk) disable iff (!rst_n)
    stack_underflow_event && !brownout_event |=> cause_q[B_UNF])
    else $error("underflow flag not set");

  pin_flag_a: assert property ( // [R5]
    @(posedge clk) disable iff (!rst_n)
    ext_reset_pin_event && !brownout_event |=> !cause_q[B_EXT])
    else $error("pin reset flag not cleared");

  instr_flag_a: assert property ( // [R6]
    @(posedge clk) disable iff (!rst_n)
    reset_instr_event && !brownout_event |=> !cause_q[B_INSTR])
    else $error("reset instruction flag not cleared");

  wdt_flag_a: assert property ( // [R4]
    @(posedge clk) disable iff (!rst_n)
    timeout && !sleep && !brownout_event |=> !cause_q[B_WDT])
    else $error("time-out flag not cleared");

  power_bits_a: assert property ( // [R7] [R8]
    @(posedge clk) disable iff (!rst_n)
    !pwr_rst && !cause_wr |=> $stable(cause_q[1:0]))
    else $error("power flags changed without a power event");

  fw_write_a: assert property ( // [R9]
    @(posedge clk) disable iff (!rst_n)
    cause_wr && !cause_hw && !brownout_event |=> cause_q == $past(wr_data))
    else $error("firmware flag write not kept");

  // window checks: an armed clear is judged only by the window
  window_closed_a: assert property ( // [R17]
    @(posedge clk) disable iff (!rst_n)
    clr_hit && windowed && armed_q && !win_open |=> wdt_reset_q)
    else $error("closed-window clear accepted");

  window_open_a: assert property ( // [R19]
    @(posedge clk) disable iff (!rst_n)
    clr_hit && windowed && armed_q && win_open |=> !wdt_reset_q)
    else $error("open-window clear refused");

  sw_enable_a: assert property ( // [R12]
    @(posedge clk) disable iff (!rst_n)
    watchdog_enable_cfg == EN_SW && !sw_enable_q |=> cnt_q == '0)
    else $error("counter ran with software enable off");

  startup_hold_a: assert property ( // [R20]
    @(posedge clk) disable iff (!rst_n)
    osc_startup_running |=> cnt_q == '0 && !pend_q)
    else $error("counter ran during startup");

  sleep_clear_a: assert property ( // [R20]
    @(posedge clk) disable iff (!rst_n)
    sleep_edge || int_wake |=> cnt_q == '0)
    else $error("sleep change did not clear counter");

  pend_tick_a: assert property ( // [R24]
    @(posedge clk) disable iff (!rst_n)
    pend_q && tick |=> cnt_q == '0)
    else $error("pending clear not applied on tick");

  period_reload_a: assert property ( // [R16]
    @(posedge clk) disable iff (!rst_n)
    any_rst && ps_sw |=> ps_q == PS_DEF)
    else $error("period not reloaded to default");

endmodule // windowed_watchdog

// >>> verif/core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// core side: register strobes and clears
// ----------------------------------------
module core_model
  import wdt_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic [7:0]                rd_data_q,
  output logic      [wdt_pkg::ADDR_W-1:0] addr = '0,
  output logic      [7:0]                wr_data = '0,
  output logic                           wr_en = 1'b0,
  output logic                           rd_en = 1'b0,
  output logic                           clear_watchdog_instr = 1'b0
);
  // firmware write, one strobe cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // data stands only in the next cycle; a ctrl0 read arms
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    // taken at the edge that closes the data cycle, before it clears
    @(posedge clk);
    d = rd_data_q;
  endtask
  // clear instruction, one strobe cycle per call
  task automatic clr();
    @(posedge clk);
    clear_watchdog_instr <= 1'b1;
    @(posedge clk);
    clear_watchdog_instr <= 1'b0;
  endtask
endmodule // core_model

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import wdt_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       sleep = 1'b0;
  logic       osr = 1'b0;
  logic       iw = 1'b0;
  logic [1:0] mode = EN_OFF;
  logic [2:0] ccs = CS_SW;
  logic [2:0] cws = WIN_SW;
  logic [4:0] cps = PS_SW;
  logic [4:0] ev = '0;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data_q, d;
  logic       wr_en, rd_en, clr_i, wdt_reset_q, wake_q;
  int         err_count = 0, cmp_count = 0, cyc = 0, n;

  always #2 clk = ~clk;

  core_model core (.clk(clk), .rd_data_q(rd_data_q), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .clear_watchdog_instr(clr_i));

  // shortened tick counts keep code-0 time-outs at 128 (low) or 160 (mid) cycles
  windowed_watchdog #(.LF_CYC(4), .MF_CYC(5)) uut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
    .watchdog_enable_cfg(mode), .cfg_clock_select(ccs), .cfg_period_select(cps),
    .cfg_window_select(cws), .sleep(sleep), .int_wake(iw), .osc_startup_running(osr),
    .clear_watchdog_instr(clr_i), .brownout_event(ev[0]), .ext_reset_pin_event(ev[1]),
    .reset_instr_event(ev[2]), .stack_overflow_event(ev[3]),
    .stack_underflow_event(ev[4]), .wdt_reset_q(wdt_reset_q), .wake_q(wake_q));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    core.rd(a, v);
    chk(nm, v, e);
  endtask
  // counts cycles until a reset (w=0) or wake (w=1) pulse, at most lim
  task automatic wait_ev(input bit w, input int lim, output int c);
    c = 0;
    do begin
      // a pulse is read at the edge that closes its cycle
      @(posedge clk);
      c++;
    end while (((w ? wake_q : wdt_reset_q) !== 1'b1) && c < lim);
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= '0;
  endtask

  task automatic t_reset();
    rchk(A_CAUSE, CAUSE_PWR, "cause");
    rchk(A_CTRL0, {2'b00, PS_DEF, 1'b0}, "ctrl0");
    rchk(A_CTRL1, {5'h00, WIN_SW}, "ctrl1");
    rchk(3'h5, 8'h00, "unmapped");
  endtask

  task automatic t_flags();
    core.wr(A_CAUSE, 8'hFF);
    rchk(A_CAUSE, 8'hFF, "fw write");
    pulse(5'h02);
    rchk(A_CAUSE, 8'hF7, "pin flag");
    pulse(5'h04);
    rchk(A_CAUSE, 8'hF3, "instr flag");
    core.wr(A_CAUSE, 8'h00);
    pulse(5'h18);
    rchk(A_CAUSE, 8'hC0, "stack flags");
    pulse(5'h01);
    rchk(A_CAUSE, CAUSE_PWR, "brownout");
  endtask

  // software mode, reserved period code gives the minimum interval
  task automatic t_sw();
    @(posedge clk);
    mode <= EN_SW;
    core.wr(A_CAUSE, 8'hFF);
    // clock field picks the mid oscillator, window field kept fully open
    core.wr(A_CTRL1, 8'h17);
    rchk(A_CTRL1, 8'h17, "ctrl1 write");
    core.wr(A_CTRL0, 8'h27);
    wait_ev(0, 300, n);
    chk("sw timeout", 8'(n inside {[150:170]}), 8'h01);
    core.rd(A_CAUSE, d);
    chk("wdt flag", {7'h00, d[B_WDT]}, 8'h00);
    rchk(A_CTRL0, {2'b00, PS_DEF, 1'b0}, "ctrl0 reload");
    wait_ev(0, 300, n);
    chk("sw off", 8'(n == 300), 8'h01);
  endtask

  task automatic t_mode();
    @(posedge clk);
    cps <= 5'h00;
    mode <= EN_ON;
    wait_ev(0, 400, n);
    wait_ev(0, 400, n);
    chk("lf period", 8'(n inside {[120:136]}), 8'h01);
    ccs <= CS_MF;
    wait_ev(0, 400, n);
    wait_ev(0, 400, n);
    chk("mf period", 8'(n inside {[150:170]}), 8'h01);
    ccs <= 3'h0;
    wait_ev(0, 400, n);
    // clears every 62 cycles never let the count reach the end
    for (int i = 0; i < 5; i++) begin
      wait_ev(0, 60, n);
      chk("cleared", 8'(n == 60), 8'h01);
      core.clr();
    end
    osr <= 1'b1;
    wait_ev(0, 300, n);
    chk("startup hold", 8'(n == 300), 8'h01);
    osr <= 1'b0;
    sleep <= 1'b1;
    wait_ev(1, 200, n);
    chk("sleep wake", 8'(n inside {[120:140]}), 8'h01);
    // an interrupt wake restarts the count, so no wake within 100 cycles
    wait_ev(1, 60, n);
    chk("pre wake", 8'(n == 60), 8'h01);
    @(posedge clk);
    iw <= 1'b1;
    @(posedge clk);
    iw <= 1'b0;
    wait_ev(1, 100, n);
    chk("int wake clear", 8'(n == 100), 8'h01);
    mode <= EN_AWAKE;
    wait_ev(1, 300, n);
    chk("awake only", 8'(n == 300), 8'h01);
    sleep <= 1'b0;
    mode <= EN_OFF;
    wait_ev(0, 300, n);
    chk("mode off", 8'(n == 300), 8'h01);
  endtask

  task automatic t_window();
    @(posedge clk);
    mode <= EN_ON;
    cws <= 3'h0;
    wait_ev(0, 400, n);
    core.wr(A_CAUSE, 8'hFF);
    core.clr();
    wait_ev(0, 2, n);
    chk("unarmed", 8'(n), 8'h01);
    core.rd(A_CAUSE, d);
    chk("wv flag", {7'h00, d[B_WV]}, 8'h00);
    core.wr(A_CAUSE, 8'hFF);
    core.rd(A_CTRL0, d);
    core.clr();
    wait_ev(0, 2, n);
    chk("closed", 8'(n), 8'h01);
    core.rd(A_CTRL0, d);
    n = 0;
    do begin
      core.rd(A_TMR, d);
      n++;
    end while (d < 8'hE0 && n < 100);
    core.clr();
    wait_ev(0, 40, n);
    chk("open armed", 8'(n == 40), 8'h01);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_flags();
    t_sw();
    t_mode();
    t_window();
    summarize();
  end
endmodule // testbench
